// ===== sisf_cfg.svh
`ifndef SISF_CFG_SVH
`define SISF_CFG_SVH

// Register offsets
`define SISF_OFS_QSTAT  16'h0000
`define SISF_OFS_DATA   16'h0001
`define SISF_OFS_LEV0   16'h0002
`define SISF_OFS_LEV1   16'h0003
`define SISF_OFS_ACLR   16'h0007
`define SISF_OFS_IRQX   16'h0014
`define SISF_OFS_IRQY   16'h0015

// Field positions
`define SISF_BIT_FLUSH  15
`define SISF_BIT_UFLOW  14
`define SISF_BIT_OFLOW  13
`define SISF_BIT_LEVEL  15
`define SISF_CNT_MSB    10
`define SISF_SLOT_MSB   11

// Reset values
`define SISF_RST_ACLR   16'h8FFF
`define SISF_RST_IRQEN  16'h0000
`define SISF_RST_FLAGS  16'h0000

// Queue capacity in bytes
`define SISF_QUEUE_DEPTH 512

`endif

// ===== sisf_pkg.sv
package sisf_pkg;

  // Register request from the serial port decoder
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } sisf_reg_req_type;

  // Per-slot events from the time slot sequencer
  typedef struct packed {
    logic [11:0] update;
    logic [11:0] crit0;
    logic [11:0] crit1;
    logic [11:0] read;
  } sisf_slot_evt_type;

endpackage

// ===== sisf_flag_bank.sv
`timescale 1ns/1ps
// Sticky flags, set has priority over any clear in the same cycle
module sisf_flag_bank #(
  parameter int W = 12
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] flags
);
  logic [W-1:0] next_flags;

  // Set wins so an event landing on a clear is never lost
  always_comb begin
    next_flags = set | (flags & ~clr);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end
endmodule

// ===== sisf_top.sv
`timescale 1ns/1ps
`include "sisf_cfg.svh"
module sisf_top
  import sisf_pkg::*;
#(
  parameter int DEPTH = `SISF_QUEUE_DEPTH
) (
  input  wire logic                        REF_CLK,
  input  wire logic                        RESET_N,
  input  wire sisf_pkg::sisf_reg_req_type  REG_REQ,
  output logic      [15:0]                 REG_RDATA,
  input  wire logic                        QUEUE_PUSH,
  input  wire logic                        QUEUE_READ,
  input  wire logic [10:0]                 QUEUE_LEVEL_LIMIT,
  input  wire sisf_pkg::sisf_slot_evt_type SLOT_EVT,
  output logic                             QUEUE_FLUSH,
  output logic                             INT_X,
  output logic                             INT_Y
);
  import sisf_pkg::*;

  localparam logic [10:0] DEPTH_C = 11'(DEPTH);

  logic [10:0] count;
  logic [10:0] next_count;
  logic [15:0] aclr;
  logic [15:0] next_aclr;
  logic [15:0] en_x;
  logic [15:0] next_en_x;
  logic [15:0] en_y;
  logic [15:0] next_en_y;
  logic [15:0] next_rdata;
  logic        next_flush;
  logic        next_int_x;
  logic        next_int_y;
  logic        push_ok;
  logic        pop_ok;
  logic        flush_ok;
  logic        level_hit;
  logic [2:0]  q_set;
  logic [2:0]  q_clr;
  logic [2:0]  q_flags;
  logic [11:0] d_clr;
  logic [11:0] data_flags;
  logic [11:0] lev0_flags;
  logic [11:0] lev1_flags;
  logic [11:0] lev0_clr;
  logic [11:0] lev1_clr;
  logic [15:0] wm_qstat;
  logic [15:0] wm_data;
  logic [15:0] wm_lev0;
  logic [15:0] wm_lev1;

  // Write-one mask for a register, zero when not addressed
  function automatic logic [15:0] w1c_mask(input sisf_reg_req_type r,
                                           input logic [15:0] ofs);
    return (r.wr && r.addr == ofs) ? r.wdata : 16'h0000;
  endfunction

  // Data status word, laid out like the interrupt enable registers
  function automatic logic [15:0] data_word(input logic [2:0] q,
                                            input logic [11:0] d);
    return {q[2], q[1], q[0], 1'b0, d};
  endfunction

  // Write-one masks held as signals, since a call result takes no select
  always_comb begin
    wm_qstat = w1c_mask(REG_REQ, `SISF_OFS_QSTAT);
    wm_data  = w1c_mask(REG_REQ, `SISF_OFS_DATA);
    wm_lev0  = w1c_mask(REG_REQ, `SISF_OFS_LEV0);
    wm_lev1  = w1c_mask(REG_REQ, `SISF_OFS_LEV1);
  end

  // Queue bookkeeping; q_* bits are {level, underrun, overrun}
  always_comb begin
    push_ok   = QUEUE_PUSH && (count < DEPTH_C);
    pop_ok    = QUEUE_READ && (count != 11'h000);
    // Flush is ignored while the queue is being touched
    flush_ok  = wm_qstat[`SISF_BIT_FLUSH]
                && !QUEUE_PUSH && !QUEUE_READ;
    next_count = count;
    if (flush_ok) begin
      next_count = 11'h000;
    end else if (push_ok && !pop_ok) begin
      next_count = count + 11'h001;
    end else if (pop_ok && !push_ok) begin
      next_count = count - 11'h001;
    end
    level_hit = push_ok && (next_count > QUEUE_LEVEL_LIMIT);
    q_set[2]  = level_hit;
    q_set[1]  = QUEUE_READ && (count == 11'h000);
    q_set[0]  = QUEUE_PUSH && (count >= DEPTH_C);
    q_clr[2]  = wm_data[`SISF_BIT_LEVEL]
                | (QUEUE_READ & aclr[`SISF_BIT_LEVEL])
                | flush_ok;
    q_clr[1]  = wm_qstat[`SISF_BIT_UFLOW]
                | flush_ok;
    q_clr[0]  = wm_qstat[`SISF_BIT_OFLOW]
                | flush_ok;
    next_flush = flush_ok;
  end

  // Slot flag clears: host write-one, plus autoclear on data read for the data flags only
  always_comb begin
    d_clr    = wm_data[11:0]
               | (SLOT_EVT.read & aclr[11:0]);
    lev0_clr = wm_lev0[11:0];
    lev1_clr = wm_lev1[11:0];
  end

  sisf_flag_bank #(.W(3)) u_queue_flags (
    .clk     (REF_CLK),
    .reset_n (RESET_N),
    .set     (q_set),
    .clr     (q_clr),
    .flags   (q_flags)
  );

  sisf_flag_bank #(.W(12)) u_data_flags (
    .clk     (REF_CLK),
    .reset_n (RESET_N),
    .set     (SLOT_EVT.update),
    .clr     (d_clr),
    .flags   (data_flags)
  );

  sisf_flag_bank #(.W(12)) u_lev0_flags (
    .clk     (REF_CLK),
    .reset_n (RESET_N),
    .set     (SLOT_EVT.update & SLOT_EVT.crit0),
    .clr     (lev0_clr),
    .flags   (lev0_flags)
  );

  sisf_flag_bank #(.W(12)) u_lev1_flags (
    .clk     (REF_CLK),
    .reset_n (RESET_N),
    .set     (SLOT_EVT.update & SLOT_EVT.crit1),
    .clr     (lev1_clr),
    .flags   (lev1_flags)
  );

  // Control registers, read-back mux and interrupt outputs
  always_comb begin
    next_aclr = aclr;
    next_en_x = en_x;
    next_en_y = en_y;
    if (REG_REQ.wr) begin
      unique case (REG_REQ.addr)
        `SISF_OFS_ACLR: next_aclr = REG_REQ.wdata & `SISF_RST_ACLR;
        `SISF_OFS_IRQX: next_en_x = REG_REQ.wdata & 16'hEFFF;
        `SISF_OFS_IRQY: next_en_y = REG_REQ.wdata & 16'hEFFF;
        default: ;
      endcase
    end
    next_rdata = REG_RDATA;
    if (REG_REQ.rd) begin
      unique case (REG_REQ.addr)
        `SISF_OFS_QSTAT: next_rdata = {1'b0, q_flags[1], q_flags[0],
                                       2'b00, count};
        `SISF_OFS_DATA:  next_rdata = {q_flags[2], 3'b000, data_flags};
        `SISF_OFS_LEV0:  next_rdata = {4'h0, lev0_flags};
        `SISF_OFS_LEV1:  next_rdata = {4'h0, lev1_flags};
        `SISF_OFS_ACLR:  next_rdata = aclr;
        `SISF_OFS_IRQX:  next_rdata = en_x;
        `SISF_OFS_IRQY:  next_rdata = en_y;
        default:         next_rdata = 16'h0000;
      endcase
    end
    // Level output, drops once every enabled flag is cleared
    next_int_x = |(data_word(q_flags, data_flags) & en_x);
    next_int_y = |(data_word(q_flags, data_flags) & en_y);
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      count       <= 11'h000;
      aclr        <= `SISF_RST_ACLR;
      en_x        <= `SISF_RST_IRQEN;
      en_y        <= `SISF_RST_IRQEN;
      REG_RDATA   <= 16'h0000;
      QUEUE_FLUSH <= 1'b0;
      INT_X       <= 1'b0;
      INT_Y       <= 1'b0;
    end else begin
      count       <= next_count;
      aclr        <= next_aclr;
      en_x        <= next_en_x;
      en_y        <= next_en_y;
      REG_RDATA   <= next_rdata;
      QUEUE_FLUSH <= next_flush;
      INT_X       <= next_int_x;
      INT_Y       <= next_int_y;
    end
  end

  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_flush_req;
    flush_ok;
  endsequence
  sequence s_queue_cleared;
    count == 11'h000 && q_flags == 3'b000 && QUEUE_FLUSH;
  endsequence

  a_queue_flush: assert property (s_flush_req |=> s_queue_cleared)
    else $error("flush did not empty queue and clear flags");
  a_underrun_set: assert property (
    QUEUE_READ && count == 11'h000 |=> q_flags[1])
    else $error("underrun flag not set on empty read");
  // A read in the same cycle may drain a full queue, so it is excluded
  a_overrun_set: assert property (
    QUEUE_PUSH && !QUEUE_READ && count == DEPTH_C
    |=> q_flags[0] && count == DEPTH_C)
    else $error("overrun flag not set or count moved when full");
  a_count_read: assert property (
    REG_REQ.rd && REG_REQ.addr == `SISF_OFS_QSTAT
    |=> REG_RDATA[10:0] == $past(count))
    else $error("byte count read back wrong");
  a_level_set: assert property (
    push_ok && !pop_ok && !flush_ok && count >= QUEUE_LEVEL_LIMIT
    |=> q_flags[2])
    else $error("level flag not set above limit");
  a_level_autoclr: assert property (
    QUEUE_READ && aclr[15] && !level_hit |=> !q_flags[2])
    else $error("level flag not autocleared on queue read");
  a_data_set: assert property (
    SLOT_EVT.update != 12'h000
    |=> (data_flags & $past(SLOT_EVT.update)) == $past(SLOT_EVT.update))
    else $error("slot data flag not set on update");
  a_data_autoclr: assert property (
    SLOT_EVT.read[0] && aclr[0] && !SLOT_EVT.update[0]
    |=> !data_flags[0])
    else $error("slot data flag not autocleared on read");
  a_crit_set: assert property (
    SLOT_EVT.update[3] && SLOT_EVT.crit0[3] && SLOT_EVT.crit1[3]
    |=> lev0_flags[3] && lev1_flags[3])
    else $error("criterion flags not set on update");
  a_zero_keeps: assert property (
    REG_REQ.wr && REG_REQ.addr == `SISF_OFS_LEV0
    && REG_REQ.wdata == 16'h0000
    |=> lev0_flags == ($past(lev0_flags)
                       | ($past(SLOT_EVT.update) & $past(SLOT_EVT.crit0))))
    else $error("writing zero changed level-zero flags");
  a_aclr_default: assert property (
    $rose(RESET_N) |-> aclr == `SISF_RST_ACLR)
    else $error("autoclear enables not enabled after reset");
  a_irq_x_level: assert property (
    (|(data_word(q_flags, data_flags) & en_x)) [*2] |-> INT_X)
    else $error("interrupt X low with enabled flag set");
  a_irq_y_idle: assert property (
    !(|(data_word(q_flags, data_flags) & en_y)) [*2] |-> !INT_Y)
    else $error("interrupt Y high with no enabled flag");
  // Slot A is the one the bench hits with a clear on the update edge
  a_set_wins: assert property (
    SLOT_EVT.update[0] && d_clr[0] |=> data_flags[0])
    else $error("clear beat a same-cycle set");
endmodule

// ===== sisf_host.sv
`timescale 1ns/1ps
// Host side of the serial register port, one word per request
module sisf_host
  import sisf_pkg::*;
(
  input  wire logic                  clk,
  output sisf_pkg::sisf_reg_req_type req,
  input  wire logic [15:0]           rdata
);
  initial req = '0;
  // Raise after an edge, hold through the taking edge, then release
  // Released address and data lines show the inverse so stale values never look valid
  task automatic access(input logic w, input logic [15:0] a,
                        input logic [15:0] d, output logic [15:0] q);
    @(posedge clk) #1;
    req = '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge clk) #1;
    q = rdata;
    req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
  import sisf_pkg::*;
  // Small depth so the overrun case stays short
  localparam int DEPTH = 8;
  typedef struct packed {logic [11:0] u, c0, c1;} sisf_row_type;
  logic              REF_CLK = 1'b0;
  logic              RESET_N = 1'b0;
  sisf_reg_req_type  req;
  logic [15:0]       rdata;
  logic              push = 1'b0;
  logic              qrd = 1'b0;
  logic [10:0]       lim = 11'h003;
  sisf_slot_evt_type evt = '0;
  logic              flush, int_x, int_y;
  logic [15:0]       q;
  int                error_cnt = 0;
  int                num_checks = 0;
  sisf_row_type      rows [4] = '{'{12'h001, 12'h001, 12'h000},
    '{12'h800, 12'h000, 12'h800}, '{12'hFFF, 12'h0F0, 12'hF00},
    '{12'hA5A, 12'hFFF, 12'h00F}};

  sisf_top #(.DEPTH(DEPTH)) sisf_top_i (.REF_CLK(REF_CLK),
    .RESET_N(RESET_N), .REG_REQ(req), .REG_RDATA(rdata),
    .QUEUE_PUSH(push), .QUEUE_READ(qrd), .QUEUE_LEVEL_LIMIT(lim),
    .SLOT_EVT(evt), .QUEUE_FLUSH(flush), .INT_X(int_x), .INT_Y(int_y));
  sisf_host sisf_host_i (.clk(REF_CLK), .req(req), .rdata(rdata));

  // 125 MHz clock
  initial forever #4 REF_CLK = ~REF_CLK;

  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: word %h, want %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: line %b, want %b", $time, g, e);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    sisf_host_i.access(1'b0, a, 16'h0000, q);
    chk_word(q, e);
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    sisf_host_i.access(1'b1, a, d, q);
  endtask
  task automatic slot(input logic [11:0] u, c0, c1, r);
    @(posedge REF_CLK) #1;
    evt = '{update: u, crit0: c0, crit1: c1, read: r};
    @(posedge REF_CLK) #1;
    evt = '0;
  endtask
  // Queue events held for n taking edges
  task automatic qev(input logic p, input logic r, input int n);
    @(posedge REF_CLK) #1;
    push = p;
    qrd = r;
    repeat (n) @(posedge REF_CLK);
    #1;
    push = 1'b0;
    qrd = 1'b0;
  endtask
  task automatic irq(input logic x, input logic y);
    repeat (2) @(posedge REF_CLK);
    #1;
    chk_bit(int_x, x);
    chk_bit(int_y, y);
  endtask
  task automatic done(input string name);
    $display("test %s finished, errors so far %0d", name, error_cnt);
  endtask
  task automatic report_and_stop;
    $display("checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Whole run needs well under 2000 cycles; allow ample margin
  initial begin
    #100000;
    error_cnt++;
    report_and_stop;
  end

  initial begin
    repeat (16) @(posedge REF_CLK);
    #1;
    RESET_N = 1'b1;
    // Reset values, unmapped and reserved places
    rd(16'h0000, 16'h0000);
    rd(16'h0007, 16'h8FFF);
    rd(16'h0014, 16'h0000);
    rd(16'h0015, 16'h0000);
    rd(16'h0004, 16'h0000);
    wr(16'h0007, 16'hFFFF);
    rd(16'h0007, 16'h8FFF);
    wr(16'h0014, 16'hFFFF);
    rd(16'h0014, 16'hEFFF);
    wr(16'h0014, 16'h0000);
    done("reset");
    // Slot update rows, then clear by writing ones
    foreach (rows[i]) begin
      slot(rows[i].u, rows[i].c0, rows[i].c1, 12'h000);
      rd(16'h0001, {4'h0, rows[i].u});
      rd(16'h0002, {4'h0, rows[i].u & rows[i].c0});
      rd(16'h0003, {4'h0, rows[i].u & rows[i].c1});
      wr(16'h0001, 16'hFFFF);
      wr(16'h0002, 16'hFFFF);
      wr(16'h0003, 16'hFFFF);
      rd(16'h0001, 16'h0000);
      rd(16'h0002, 16'h0000);
    end
    done("rows");
    // Zero write keeps, autoclear on and off
    slot(12'h003, 12'h000, 12'h000, 12'h000);
    wr(16'h0001, 16'h0000);
    rd(16'h0001, 16'h0003);
    slot(12'h000, 12'h000, 12'h000, 12'h002);
    rd(16'h0001, 16'h0001);
    wr(16'h0007, 16'h0000);
    slot(12'h000, 12'h000, 12'h000, 12'h001);
    rd(16'h0001, 16'h0001);
    done("autoclear");
    // Update and clear on the same edge
    fork
      wr(16'h0001, 16'h0001);
      slot(12'h001, 12'h000, 12'h000, 12'h000);
    join
    rd(16'h0001, 16'h0001);
    done("set wins");
    // Interrupt lines follow enabled flags
    wr(16'h0014, 16'h0001);
    irq(1'b1, 1'b0);
    wr(16'h0015, 16'h0001);
    irq(1'b1, 1'b1);
    wr(16'h0001, 16'h0001);
    irq(1'b0, 1'b0);
    done("irq");
    // Fill past depth, limit and overrun
    qev(1'b1, 1'b0, DEPTH + 1);
    rd(16'h0000, 16'h2000 | 16'(DEPTH));
    rd(16'h0001, 16'h8000);
    wr(16'h0014, 16'h2000);
    irq(1'b1, 1'b0);
    wr(16'h0007, 16'h8000);
    qev(1'b0, 1'b1, 1);
    rd(16'h0001, 16'h0000);
    wr(16'h0000, 16'h2000);
    rd(16'h0000, 16'(DEPTH - 1));
    done("fill");
    // Flush, empty read, refused flush
    qev(1'b1, 1'b0, 1);
    rd(16'h0001, 16'h8000);
    wr(16'h0000, 16'h8000);
    // Flush pulse stands for the cycle after the taking edge
    chk_bit(flush, 1'b1);
    rd(16'h0000, 16'h0000);
    rd(16'h0001, 16'h0000);
    qev(1'b0, 1'b1, 1);
    rd(16'h0000, 16'h4000);
    fork
      wr(16'h0000, 16'h8000);
      qev(1'b1, 1'b0, 1);
    join
    chk_bit(flush, 1'b0);
    rd(16'h0000, 16'h4001);
    wr(16'h0000, 16'h8000);
    chk_bit(flush, 1'b1);
    rd(16'h0000, 16'h0000);
    done("flush");
    // Mid-run reset brings the enables back to their defaults
    wr(16'h0014, 16'h0001);
    @(posedge REF_CLK) #1;
    RESET_N = 1'b0;
    repeat (2) @(posedge REF_CLK);
    #1;
    RESET_N = 1'b1;
    rd(16'h0007, 16'h8FFF);
    rd(16'h0014, 16'h0000);
    rd(16'h0000, 16'h0000);
    irq(1'b0, 1'b0);
    done("reset again");
    report_and_stop;
  end
endmodule
